// >>> sram_slave_regs.svh
// Named constants for the two-wire SRAM slave front end.
`ifndef SRAM_SLAVE_REGS_SVH
`define SRAM_SLAVE_REGS_SVH

// Control register addresses.
`define REG_STATUS_ADDR    8'h00
`define REG_COMMAND_ADDR   8'h55

// Software command codes written to the command register.
`define CMD_SW_STORE       8'h33
`define CMD_SW_RECALL      8'hdd

// Op codes in the upper nibble of the control byte.
`define OPC_SRAM           4'ha
`define OPC_CTRL           4'h3

// Control byte field positions.
`define CTL_OPC_MSB        7
`define CTL_OPC_LSB        4
`define CTL_CS_HIGH_BIT    3
`define CTL_CS_LOW_BIT     2
`define CTL_CS_FIXED_BIT   1
`define CTL_RW_BIT         0
`define CTL_CS_FIXED_VAL   1'b0
`define CTL_RW_READ        1'b1

// Status register field positions and reset values.
`define ST_AM_BIT          7
`define ST_BP_MSB          4
`define ST_BP_LSB          2
`define ST_ASE_BIT         1
`define ST_EVENT_BIT       0
`define ST_BP_RESET        3'h0
`define ST_BP_ALL          3'h7
`define ST_BP_NONE         3'h0
`define ST_ASE_RESET       1'b0
`define ST_EVENT_RESET     1'b0

// Bit counting within a byte.
`define BIT_CNT_RESET      4'h0
`define BIT_CNT_LAST       4'h8
`define BYTE_RESET         8'h00

`endif

// >>> sram_slave_pkg.sv
// Types shared by the two-wire SRAM slave front end.
package sram_slave_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CTRL,
    ST_PTR_HI,
    ST_PTR_LO,
    ST_WDATA,
    ST_REG_ADDR,
    ST_REG_DATA,
    ST_READ,
    ST_IGNORE
  } slave_state_t;

endpackage

// >>> pin_sync.sv
// Two flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The reset value is all ones so an idle bus reads released.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// >>> write_fifo.sv
// Write buffer between the serial receiver and the SRAM array.
`timescale 1ns/1ps
module write_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
  assign out_valid_o = (wr_q != rd_q);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_q[PW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule

// >>> sram_serial_slave.sv
// Two-wire serial slave with SRAM array and control registers.
`timescale 1ns/1ps
`include "sram_slave_regs.svh"
module sram_serial_slave #(
  parameter int AW         = 11,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n_o,
  input  wire logic chip_select_high_pin_i,
  input  wire logic chip_select_low_pin_i,
  input  wire logic backup_cap_voltage_low_i,
  input  wire logic store_request_i,
  input  wire logic store_recall_done_i,
  output logic      sw_store_o,
  output logic      sw_recall_o,
  output logic      store_abort_o,
  output logic      auto_store_enable_o,
  output logic      array_modified_o
);

  localparam int DEPTH = 1 << AW;
  localparam int FW    = AW + 8;

  // Synchronised pins.
  logic [5:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       cs_high_s;
  logic       cs_low_s;
  logic       cap_low_s;
  logic       store_req_s;

  pin_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({scl_i, sda_i, chip_select_high_pin_i, chip_select_low_pin_i,
               backup_cap_voltage_low_i, store_request_i}),
    .sync_o  (pins_s)
  );

  assign scl_s       = pins_s[5];
  assign sda_s       = pins_s[4];
  assign cs_high_s   = pins_s[3];
  assign cs_low_s    = pins_s[2];
  assign cap_low_s   = pins_s[1];
  assign store_req_s = pins_s[0];

  // Bus condition detection on the synchronised lines.
  logic scl_prev_q;
  logic sda_prev_q;
  logic store_prev_q;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic store_ev;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_prev_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
      // The synchroniser leaves reset high, so a low here would fake an edge.
      store_prev_q <= 1'b1;
    end else begin
      scl_prev_q   <= scl_s;
      sda_prev_q   <= sda_s;
      store_prev_q <= store_req_s;
    end
  end

  assign start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_ev  = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign store_ev = store_req_s && !store_prev_q;

  // Protected when the address lies in the upper part chosen by the field.
  function automatic logic is_protected(input logic [AW-1:0] a, input logic [2:0] bp);
    logic [AW:0] span;
    span = (AW + 1)'(DEPTH) >> (`ST_BP_ALL - bp);
    if (bp == `ST_BP_NONE) begin
      return 1'b0;
    end else if (bp == `ST_BP_ALL) begin
      return 1'b1;
    end
    return {1'b0, a} >= ((AW + 1)'(DEPTH) - span);
  endfunction

  // Byte framing state.
  sram_slave_pkg::slave_state_t st_q;
  sram_slave_pkg::slave_state_t next_q;
  logic [3:0]    bit_cnt_q;
  logic          ack_phase_q;
  logic          ack_q;
  logic          drive_q;
  logic [7:0]    shift_q;
  logic [7:0]    tx_q;
  logic          mack_q;
  logic          reg_read_q;
  logic [7:0]    addr_hi_q;
  logic [7:0]    reg_addr_q;
  logic [AW-1:0] ptr_q;
  logic [7:0]    rd_data_q;
  logic [2:0]    bp_q;
  logic          ase_q;
  logic          event_q;
  logic          am_q;
  logic [7:0]    status_byte;
  logic          busy;
  logic          byte_end;
  logic          ack_rise;
  logic          ack_end;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic          wr_commit;

  assign busy     = (st_q != sram_slave_pkg::ST_IDLE) && (st_q != sram_slave_pkg::ST_IGNORE);
  assign byte_end = scl_fall && !ack_phase_q && (bit_cnt_q == `BIT_CNT_LAST);
  assign ack_rise = scl_rise && ack_phase_q;
  assign ack_end  = scl_fall && ack_phase_q;
  assign wr_commit = ack_rise && ack_q && (st_q == sram_slave_pkg::ST_WDATA);

  always_comb begin
    status_byte                          = `BYTE_RESET;
    status_byte[`ST_AM_BIT]              = am_q;
    status_byte[`ST_BP_MSB:`ST_BP_LSB]   = bp_q;
    status_byte[`ST_ASE_BIT]             = ase_q;
    status_byte[`ST_EVENT_BIT]           = event_q;
  end

  // Bit counter and receive shift register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_q <= `BIT_CNT_RESET;
      shift_q   <= `BYTE_RESET;
    end else if (start_ev || stop_ev) begin
      bit_cnt_q <= `BIT_CNT_RESET;
    end else if (scl_rise && !ack_phase_q) begin
      shift_q   <= {shift_q[6:0], sda_s};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (byte_end) begin
      bit_cnt_q <= `BIT_CNT_RESET;
    end
  end

  // Acknowledge decision at the end of each byte; state change at the end of the ninth bit.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q        <= sram_slave_pkg::ST_IDLE;
      next_q      <= sram_slave_pkg::ST_IDLE;
      ack_phase_q <= 1'b0;
      ack_q       <= 1'b0;
      reg_read_q  <= 1'b0;
      mack_q      <= 1'b1;
    end else if (start_ev) begin
      st_q        <= sram_slave_pkg::ST_CTRL;
      ack_phase_q <= 1'b0;
      ack_q       <= 1'b0;
    end else if (stop_ev) begin
      st_q        <= sram_slave_pkg::ST_IDLE;
      ack_phase_q <= 1'b0;
      ack_q       <= 1'b0;
    end else if (store_ev && busy) begin
      st_q        <= sram_slave_pkg::ST_IGNORE;
      ack_phase_q <= 1'b0;
      ack_q       <= 1'b0;
    end else if (byte_end && busy) begin
      ack_phase_q <= 1'b1;
      case (st_q)
        sram_slave_pkg::ST_CTRL: begin
          ack_q <= !cap_low_s && (shift_q[`CTL_CS_HIGH_BIT] == cs_high_s)
                   && (shift_q[`CTL_CS_LOW_BIT] == cs_low_s)
                   && (shift_q[`CTL_CS_FIXED_BIT] == `CTL_CS_FIXED_VAL)
                   && ((shift_q[`CTL_OPC_MSB:`CTL_OPC_LSB] == `OPC_SRAM)
                   || (shift_q[`CTL_OPC_MSB:`CTL_OPC_LSB] == `OPC_CTRL));
          reg_read_q <= (shift_q[`CTL_OPC_MSB:`CTL_OPC_LSB] == `OPC_CTRL);
          if (shift_q[`CTL_RW_BIT] == `CTL_RW_READ) begin
            next_q <= sram_slave_pkg::ST_READ;
          end else if (shift_q[`CTL_OPC_MSB:`CTL_OPC_LSB] == `OPC_SRAM) begin
            next_q <= sram_slave_pkg::ST_PTR_HI;
          end else begin
            next_q <= sram_slave_pkg::ST_REG_ADDR;
          end
        end
        sram_slave_pkg::ST_PTR_HI: begin
          ack_q  <= 1'b1;
          next_q <= sram_slave_pkg::ST_PTR_LO;
        end
        sram_slave_pkg::ST_PTR_LO: begin
          ack_q  <= 1'b1;
          next_q <= sram_slave_pkg::ST_WDATA;
        end
        sram_slave_pkg::ST_WDATA: begin
          // A full buffer is refused like a protected byte so nothing is lost.
          ack_q  <= !is_protected(ptr_q, bp_q) && fifo_in_ready;
          next_q <= sram_slave_pkg::ST_WDATA;
        end
        sram_slave_pkg::ST_REG_ADDR: begin
          ack_q  <= (shift_q == `REG_STATUS_ADDR) || (shift_q == `REG_COMMAND_ADDR);
          next_q <= sram_slave_pkg::ST_REG_DATA;
        end
        sram_slave_pkg::ST_REG_DATA: begin
          if (reg_addr_q == `REG_COMMAND_ADDR) begin
            ack_q <= (shift_q == `CMD_SW_STORE) || (shift_q == `CMD_SW_RECALL);
          end else begin
            ack_q <= 1'b1;
          end
          next_q <= sram_slave_pkg::ST_REG_DATA;
        end
        sram_slave_pkg::ST_READ: begin
          ack_q  <= 1'b1;
          next_q <= sram_slave_pkg::ST_READ;
        end
        default: begin
          ack_q  <= 1'b0;
          next_q <= sram_slave_pkg::ST_IGNORE;
        end
      endcase
    end else if (ack_rise) begin
      mack_q <= sda_s;
    end else if (ack_end) begin
      ack_phase_q <= 1'b0;
      if (st_q == sram_slave_pkg::ST_READ) begin
        st_q <= mack_q ? sram_slave_pkg::ST_IGNORE : sram_slave_pkg::ST_READ;
      end else if (ack_q) begin
        st_q <= next_q;
      end else begin
        st_q <= sram_slave_pkg::ST_IGNORE;
      end
    end
  end

  // Address bytes for the pointer and the register address.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_hi_q  <= `BYTE_RESET;
      reg_addr_q <= `BYTE_RESET;
    end else if (byte_end) begin
      if (st_q == sram_slave_pkg::ST_PTR_HI) begin
        addr_hi_q <= shift_q;
      end
      if (st_q == sram_slave_pkg::ST_REG_ADDR) begin
        reg_addr_q <= shift_q;
      end
    end
  end

  // Address pointer: loaded by the address phase, advanced per committed or sent array byte.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= '0;
    end else if (byte_end && (st_q == sram_slave_pkg::ST_PTR_LO)) begin
      ptr_q <= AW'({addr_hi_q, shift_q});
    end else if (wr_commit) begin
      ptr_q <= ptr_q + 1'b1;
    end else if (ack_rise && (st_q == sram_slave_pkg::ST_READ) && !reg_read_q) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // Data line drive: acknowledge while receiving, data bits while sending.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_q <= 1'b0;
      tx_q    <= `BYTE_RESET;
    end else if (start_ev || stop_ev || (store_ev && busy)) begin
      drive_q <= 1'b0;
    end else if (byte_end) begin
      if (busy && (st_q != sram_slave_pkg::ST_READ)) begin
        case (st_q)
          sram_slave_pkg::ST_CTRL: begin
            drive_q <= !cap_low_s && (shift_q[`CTL_CS_HIGH_BIT] == cs_high_s)
                       && (shift_q[`CTL_CS_LOW_BIT] == cs_low_s)
                       && (shift_q[`CTL_CS_FIXED_BIT] == `CTL_CS_FIXED_VAL)
                       && ((shift_q[`CTL_OPC_MSB:`CTL_OPC_LSB] == `OPC_SRAM)
                       || (shift_q[`CTL_OPC_MSB:`CTL_OPC_LSB] == `OPC_CTRL));
          end
          sram_slave_pkg::ST_WDATA: begin
            drive_q <= !is_protected(ptr_q, bp_q) && fifo_in_ready;
          end
          sram_slave_pkg::ST_REG_ADDR: begin
            drive_q <= (shift_q == `REG_STATUS_ADDR) || (shift_q == `REG_COMMAND_ADDR);
          end
          sram_slave_pkg::ST_REG_DATA: begin
            drive_q <= (reg_addr_q != `REG_COMMAND_ADDR) || (shift_q == `CMD_SW_STORE)
                       || (shift_q == `CMD_SW_RECALL);
          end
          default: begin
            drive_q <= 1'b1;
          end
        endcase
      end else begin
        drive_q <= 1'b0;
      end
    end else if (ack_end) begin
      if ((st_q == sram_slave_pkg::ST_READ && !mack_q)
          || (st_q == sram_slave_pkg::ST_CTRL && ack_q && next_q == sram_slave_pkg::ST_READ)) begin
        tx_q    <= reg_read_q ? status_byte : rd_data_q;
        drive_q <= reg_read_q ? !status_byte[7] : !rd_data_q[7];
      end else begin
        drive_q <= 1'b0;
      end
    end else if (scl_fall && (st_q == sram_slave_pkg::ST_READ) && !ack_phase_q
                 && (bit_cnt_q != `BIT_CNT_RESET)) begin
      tx_q    <= {tx_q[6:0], 1'b0};
      drive_q <= !tx_q[6];
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = !drive_q;

  // Status register and software commands, committed on the acknowledge rising edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bp_q        <= `ST_BP_RESET;
      ase_q       <= `ST_ASE_RESET;
      event_q     <= `ST_EVENT_RESET;
      sw_store_o  <= 1'b0;
      sw_recall_o <= 1'b0;
    end else begin
      sw_store_o  <= 1'b0;
      sw_recall_o <= 1'b0;
      if (ack_rise && ack_q && (st_q == sram_slave_pkg::ST_REG_DATA)) begin
        if (reg_addr_q == `REG_STATUS_ADDR) begin
          bp_q    <= shift_q[`ST_BP_MSB:`ST_BP_LSB];
          ase_q   <= shift_q[`ST_ASE_BIT];
          event_q <= shift_q[`ST_EVENT_BIT];
        end else begin
          sw_store_o  <= (shift_q == `CMD_SW_STORE);
          sw_recall_o <= (shift_q == `CMD_SW_RECALL);
        end
      end
    end
  end

  // Array modified flag: a write in the same cycle as completion keeps it set.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      am_q <= 1'b0;
    end else if (wr_commit) begin
      am_q <= 1'b1;
    end else if (store_recall_done_i) begin
      am_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      store_abort_o <= 1'b0;
    end else begin
      store_abort_o <= store_ev;
    end
  end

  assign auto_store_enable_o = ase_q;
  assign array_modified_o    = am_q;

  // Committed bytes queue here; the single array port drains them outside reads.
  assign fifo_out_ready = (st_q != sram_slave_pkg::ST_READ);

  write_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_commit),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({ptr_q, shift_q}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  logic [7:0] sram [DEPTH];

  always_ff @(posedge clk_i) begin
    if (fifo_out_valid && fifo_out_ready) begin
      sram[fifo_out_data[FW-1:8]] <= fifo_out_data[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_q <= `BYTE_RESET;
    end else begin
      rd_data_q <= sram[ptr_q];
    end
  end

endmodule

// >>> bus_master_model.sv
// Two-wire bus master model that drives the clock and pulls the data line.
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic gap();
    repeat (10) @(posedge clk_i);
  endtask
  // Data changes only while the clock is low; the line is sampled mid-high.
  task automatic bit_x(input logic b, output logic s);
    sda_low_o <= ~b;
    gap();
    scl_o <= 1'b1;
    gap();
    s = sda_i;
    gap();
    scl_o <= 1'b0;
    gap();
  endtask
  task automatic start_c();
    sda_low_o <= 1'b0;
    gap();
    scl_o <= 1'b1;
    gap();
    sda_low_o <= 1'b1;
    gap();
    scl_o <= 1'b0;
    gap();
  endtask
  task automatic stop_c();
    sda_low_o <= 1'b1;
    gap();
    scl_o <= 1'b1;
    gap();
    sda_low_o <= 1'b0;
    gap();
    gap();
  endtask
  // The ninth clock carries the receiver's acknowledge.
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, ack);
  endtask
  task automatic rd(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, s);
  endtask
endmodule

// >>> sram_serial_slave_checker.sv
// Concurrent checks on the ports of the two-wire SRAM slave.
`timescale 1ns/1ps
module sram_serial_slave_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic store_request_i,
  input wire logic store_recall_done_i,
  input wire logic sw_store_o,
  input wire logic sw_recall_o,
  input wire logic store_abort_o,
  input wire logic array_modified_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_sda_out_low: assert property (sda_o == 1'b0)
    else $error("data output not low");
  chk_drive_scl_low: assert property ($fell(sda_oe_n_o) |-> !scl_i)
    else $error("data drive began with clock high");
  chk_ack_hold_high: assert property (!sda_oe_n_o && $rose(scl_i) |=> !sda_oe_n_o [*8])
    else $error("driven low level dropped in clock high");
  chk_store_pulse_one: assert property (sw_store_o |=> !sw_store_o)
    else $error("store pulse too long");
  chk_recall_pulse_one: assert property (sw_recall_o |=> !sw_recall_o)
    else $error("recall pulse too long");
  chk_cmd_exclusive: assert property (!(sw_store_o && sw_recall_o))
    else $error("store and recall together");
  chk_abort_follows_req: assert property ($rose(store_request_i) |-> ##[1:6] store_abort_o)
    else $error("no abort after store request");
  chk_abort_single: assert property (store_abort_o |=> !store_abort_o)
    else $error("abort pulse too long");
  chk_abort_releases: assert property (store_abort_o |-> ##[0:3] sda_oe_n_o)
    else $error("data line held after abort");
  chk_am_clear_cause: assert property ($fell(array_modified_o) |-> $past(store_recall_done_i))
    else $error("modified flag cleared without done");
  chk_am_set_on_ack: assert property ($rose(array_modified_o) |-> scl_i && !sda_i)
    else $error("modified flag set outside ack high");
endmodule
bind sram_serial_slave sram_serial_slave_checker i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .store_request_i(store_request_i),
  .store_recall_done_i(store_recall_done_i), .sw_store_o(sw_store_o),
  .sw_recall_o(sw_recall_o), .store_abort_o(store_abort_o),
  .array_modified_o(array_modified_o));

// >>> sram_serial_slave_tb.sv
// Self-checking bench for the two-wire SRAM slave and its write buffer.
`timescale 1ns/1ps
module sram_serial_slave_tb;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, cs_hi = 1'b1, cs_lo = 1'b0;
  logic       cap_low = 1'b0, st_req = 1'b0, sr_done = 1'b0;
  logic       scl, m_low, oe_n, sda_out, sw_st, sw_rc, abrt;
  logic       ase, am, ack_s;
  logic [7:0] rd_s;
  logic [7:0] bad [5] = '{8'ha4, 8'ha0, 8'haa, 8'hb8, 8'h28};
  wire        sda = ~(m_low | ~oe_n);
  int         n_mismatch = 0, cmp_count = 0, cyc = 0, n_st = 0, n_rc = 0, n_ab = 0, n;
  bus_master_model i_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  sram_serial_slave #(.AW(11), .FIFO_DEPTH(32)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
    .sda_oe_n_o(oe_n), .chip_select_high_pin_i(cs_hi), .chip_select_low_pin_i(cs_lo),
    .backup_cap_voltage_low_i(cap_low), .store_request_i(st_req),
    .store_recall_done_i(sr_done), .sw_store_o(sw_st), .sw_recall_o(sw_rc),
    .store_abort_o(abrt), .auto_store_enable_o(ase), .array_modified_o(am));
  initial forever #2 clk_i = ~clk_i;
  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    n_st += (sw_st === 1'b1);
    n_rc += (sw_rc === 1'b1);
    n_ab += (abrt === 1'b1);
    if (cyc == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic ea);
    logic a;
    i_master.wr(b, a);
    chk("ack", {7'h00, ea}, {7'h00, a});
  endtask
  task automatic rb(input logic [7:0] e, input logic nack);
    logic [7:0] d;
    i_master.rd(nack, d);
    chk("rdata", e, d);
  endtask
  task automatic sram_at(input logic [10:0] p);
    i_master.start_c();
    wb(8'ha8, 1'b0);
    wb({5'h00, p[10:8]}, 1'b0);
    wb(p[7:0], 1'b0);
  endtask
  // Pointer set by a write, then a repeated Start into a read.
  task automatic rd_from(input logic [10:0] p);
    sram_at(p);
    i_master.start_c();
    wb(8'ha9, 1'b0);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, input logic ea, input logic ed);
    i_master.start_c();
    wb(8'h38, 1'b0);
    wb(a, ea);
    wb(d, ed);
    i_master.stop_c();
  endtask
  task automatic status_is(input logic [7:0] e);
    i_master.start_c();
    wb(8'h39, 1'b0);
    rb(e, 1'b1);
    i_master.stop_c();
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    sram_at(11'h7e0);
    wb(8'h5e, 1'b0);
    i_master.stop_c();
    sram_at(11'h010);
    wb(8'ha5, 1'b0);
    wb(8'h3c, 1'b0);
    wb(8'h5a, 1'b0);
    i_master.stop_c();
    rd_from(11'h010);
    rb(8'ha5, 1'b0);
    rb(8'h3c, 1'b1);
    i_master.stop_c();
    i_master.start_c();
    wb(8'ha9, 1'b0);
    rb(8'h5a, 1'b1);
    i_master.stop_c();
    sram_at(11'h7ff);
    wb(8'h11, 1'b0);
    wb(8'h22, 1'b0);
    i_master.stop_c();
    rd_from(11'h7ff);
    rb(8'h11, 1'b0);
    rb(8'h22, 1'b1);
    i_master.stop_c();
    foreach (bad[k]) begin
      i_master.start_c();
      wb(bad[k], 1'b1);
      wb(8'h00, 1'b1);
      i_master.stop_c();
    end
    cs_hi <= 1'b0;
    cs_lo <= 1'b1;
    i_master.start_c();
    wb(8'ha4, 1'b0);
    i_master.stop_c();
    cs_hi <= 1'b1;
    cs_lo <= 1'b0;
    cap_low <= 1'b1;
    i_master.start_c();
    wb(8'ha8, 1'b1);
    i_master.stop_c();
    cap_low <= 1'b0;
    reg_wr(8'h00, 8'h06, 1'b0, 1'b0);
    status_is(8'h86);
    chk("ase", 8'h01, {7'h00, ase});
    sram_at(11'h7df);
    wb(8'h77, 1'b0);
    wb(8'h88, 1'b1);
    wb(8'h99, 1'b1);
    i_master.stop_c();
    i_master.start_c();
    wb(8'ha9, 1'b0);
    rb(8'h5e, 1'b1);
    i_master.stop_c();
    reg_wr(8'h00, 8'h00, 1'b0, 1'b0);
    reg_wr(8'h55, 8'h33, 1'b0, 1'b0);
    reg_wr(8'h55, 8'hdd, 1'b0, 1'b0);
    reg_wr(8'h55, 8'h12, 1'b0, 1'b1);
    reg_wr(8'h20, 8'h33, 1'b1, 1'b1);
    chk("sw_store", 8'h01, n_st[7:0]);
    chk("sw_recall", 8'h01, n_rc[7:0]);
    sr_done <= 1'b1;
    @(posedge clk_i);
    sr_done <= 1'b0;
    status_is(8'h00);
    sram_at(11'h100);
    fork
      wb(8'h66, 1'b1);
      begin
        repeat (100) @(posedge clk_i);
        st_req <= 1'b1;
      end
    join
    wb(8'h44, 1'b1);
    i_master.stop_c();
    chk("abort", 8'h01, n_ab[7:0]);
    st_req <= 1'b0;
    // Stream a run of bytes through the write buffer, then read them back.
    n = 0;
    sram_at(11'h200);
    for (int k = 0; k < 32; k++) begin
      i_master.wr(k[7:0], ack_s);
      if (ack_s === 1'b0) n++;
    end
    i_master.stop_c();
    chk("fifo_fill", 8'h20, n[7:0]);
    rd_from(11'h200);
    for (int k = 0; k < 32; k++) begin
      i_master.rd(k == 31, rd_s);
      chk("fifo_data", k[7:0], rd_s);
    end
    i_master.stop_c();
    chk("am_out", 8'h01, {7'h00, am});
    end_sim();
  end
endmodule
